// [shared/ios_params.svh]
`ifndef IOS_PARAMS_SVH
`define IOS_PARAMS_SVH

// Clock and hold window of the reset button
`define IOS_CLK_HZ        40000000
`define IOS_HOLD_MIN_S    3
`define IOS_HOLD_MAX_S    15
`define IOS_HOLD_CNT_W    32

// Protocol addresses (register number minus one)
`define IOS_ADDR_Q1       16'h7d01
`define IOS_ADDR_S1       16'h7d02
`define IOS_ADDR_Q2       16'h7d03
`define IOS_ADDR_S2       16'h7d04

// Function and exception codes
`define IOS_FN_RD_HOLD    8'h03
`define IOS_FN_RD_INPUT   8'h04
`define IOS_EXC_FUNC      8'h01
`define IOS_EXC_ADDR      8'h02
`define IOS_EXC_VALUE     8'h03
`define IOS_MAX_QTY       8'h7d

// Status word layout
`define IOS_DI_W          6
`define IOS_DO_W          3
`define IOS_AUX_W         2
`define IOS_FIRST_W       11
`define IOS_SECOND_W      9
`define IOS_RSV1_W        4
`define IOS_RSV2_W        6
`define IOS_UNAVAIL_BIT   15
`define IOS_TRIP_W        15

// Strap capture delay after reset release
`define IOS_STRAP_CNT     3'h5

`endif

// [shared/ios_pkg.sv]
package ios_pkg;

	typedef logic [15:0] ios_word_t;

	typedef enum logic [1:0] {
		IOS_VAR_BASIC    = 2'b00,
		IOS_VAR_EXTENDED = 2'b01,
		IOS_VAR_CONTROL  = 2'b10
	} ios_variant_t;

	typedef enum logic [0:0] {
		IOS_KEY_IDLE      = 1'b0,
		IOS_KEY_VALIDATED = 1'b1
	} ios_key_state_t;

	typedef enum logic [1:0] {
		IOS_RSP_IDLE   = 2'b00,
		IOS_RSP_STREAM = 2'b01,
		IOS_RSP_EXC    = 2'b10
	} ios_rsp_state_t;

endpackage

// [shared/ios_trip_if.sv]
`timescale 1ns/1ps
`include "ios_params.svh"

interface ios_trip_if;
	import ios_pkg::*;

	logic [`IOS_TRIP_W-1:0] trip_ev;
	logic                   key;
	logic                   closed;
	logic                   button;
	ios_variant_t           variant;
	logic [`IOS_TRIP_W-1:0] cause;

	modport ctrl (output trip_ev, output key, output closed, output button,
		output variant, input cause);
	modport latch (input trip_ev, input key, input closed, input button,
		input variant, output cause);
endinterface

// [rtl/ios_sync.sv]
`timescale 1ns/1ps

module ios_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] out_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Accept a bit once stages two and three agree
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_q <= '0;
		end else begin
			out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
		end
	end

	assign dout = out_q;

endmodule

// [rtl/ios_trip_latch.sv]
`timescale 1ns/1ps
`include "ios_params.svh"

module ios_trip_latch
	import ios_pkg::*;
#(
	parameter logic [`IOS_HOLD_CNT_W-1:0] HOLD_MIN = '1,
	parameter logic [`IOS_HOLD_CNT_W-1:0] HOLD_MAX = '1
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	ios_trip_if.latch tif
);

	logic                       key_prev_q;
	logic                       closed_prev_q;
	logic                       button_prev_q;
	ios_key_state_t             key_st_q;
	logic [`IOS_HOLD_CNT_W-1:0] hold_q;
	logic [`IOS_TRIP_W-1:0]     cause_q;
	logic                       key_rise;
	logic                       closed_rise;
	logic                       button_fall;
	logic                       any_cause;
	logic                       clr;

	assign key_rise    = tif.key & ~key_prev_q;
	assign closed_rise = tif.closed & ~closed_prev_q;
	assign button_fall = ~tif.button & button_prev_q;
	assign any_cause   = |cause_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			key_prev_q    <= 1'b0;
			closed_prev_q <= 1'b0;
			button_prev_q <= 1'b0;
		end else begin
			key_prev_q    <= tif.key;
			closed_prev_q <= tif.closed;
			button_prev_q <= tif.button;
		end
	end

	// Two presses: validate, then confirm
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			key_st_q <= IOS_KEY_IDLE;
		end else if (tif.variant != IOS_VAR_BASIC) begin
			key_st_q <= IOS_KEY_IDLE;
		end else if (key_rise) begin
			case (key_st_q)
				IOS_KEY_IDLE:      key_st_q <= any_cause ? IOS_KEY_VALIDATED : IOS_KEY_IDLE;
				IOS_KEY_VALIDATED: key_st_q <= IOS_KEY_IDLE;
				default:           key_st_q <= IOS_KEY_IDLE;
			endcase
		end
	end

	// Press duration, saturating above the window
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hold_q <= '0;
		end else if (!tif.button) begin
			hold_q <= '0;
		end else if (hold_q <= HOLD_MAX) begin
			hold_q <= hold_q + 1'b1;
		end
	end

	always_comb begin
		case (tif.variant)
			IOS_VAR_BASIC:    clr = key_rise && key_st_q == IOS_KEY_VALIDATED;
			IOS_VAR_EXTENDED: clr = closed_rise;
			IOS_VAR_CONTROL:  clr = button_fall && hold_q >= HOLD_MIN && hold_q <= HOLD_MAX;
			default:          clr = 1'b0;
		endcase
	end

	// New trip wins over a clear in the same cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cause_q <= '0;
		end else begin
			cause_q <= (cause_q & ~{`IOS_TRIP_W{clr}}) | tif.trip_ev;
		end
	end

	assign tif.cause = cause_q;

endmodule

// [rtl/ios_status_regs.sv]
`timescale 1ns/1ps
`include "ios_params.svh"

module ios_status_regs
	import ios_pkg::*;
#(
	parameter logic [`IOS_HOLD_CNT_W-1:0] HOLD_MIN =
		`IOS_HOLD_CNT_W'(`IOS_HOLD_MIN_S * `IOS_CLK_HZ),
	parameter logic [`IOS_HOLD_CNT_W-1:0] HOLD_MAX =
		`IOS_HOLD_CNT_W'(`IOS_HOLD_MAX_S * `IOS_CLK_HZ)
) (
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	input  wire logic [`IOS_DI_W-1:0]          first_io_module_in,
	input  wire logic [`IOS_DO_W-1:0]          first_io_module_out,
	input  wire logic [`IOS_AUX_W-1:0]         auxiliary_contact_module_out,
	input  wire logic [`IOS_FIRST_W-1:0]       first_io_module_bit_ok,
	input  wire logic                          first_io_module_unavail,
	input  wire logic [`IOS_DI_W-1:0]          second_io_module_in,
	input  wire logic [`IOS_DO_W-1:0]          second_io_module_out,
	input  wire logic [`IOS_SECOND_W-1:0]      second_io_module_bit_ok,
	input  wire logic                          second_io_module_unavail,
	input  wire logic [`IOS_TRIP_W-1:0]        trip_event,
	input  wire logic                          confirm_key,
	input  wire logic                          breaker_closed,
	input  wire logic                          reset_button,
	input  wire logic [1:0]                    trip_unit_variant,
	input  wire logic                          req_valid,
	input  wire logic [7:0]                    req_func,
	input  wire logic [15:0]                   req_addr,
	input  wire logic [7:0]                    req_qty,
	output logic                               req_ready,
	output logic                               rsp_valid,
	output logic [15:0]                        rsp_data,
	output logic                               rsp_last,
	output logic                               rsp_exc,
	output logic [7:0]                         rsp_exc_code,
	output logic [`IOS_TRIP_W-1:0]             trip_cause
);

	localparam int FW = `IOS_FIRST_W + 1;
	localparam int SW = `IOS_SECOND_W + 1;
	localparam int TW = `IOS_TRIP_W + 3 + 2;

	ios_trip_if tif ();

	logic [FW-1:0]          first_s;
	logic [SW-1:0]          second_s;
	logic [TW-1:0]          trip_s;
	logic [2:0]             strap_cnt_q;
	ios_variant_t           variant_q;
	ios_word_t              q1;
	ios_word_t              s1;
	ios_word_t              q2;
	ios_word_t              s2;
	ios_word_t              rd_word;
	ios_rsp_state_t         st_q;
	logic [15:0]            ptr_q;
	logic [7:0]             left_q;
	logic                   req_ready_q;
	logic                   rsp_valid_q;
	logic [15:0]            rsp_data_q;
	logic                   rsp_last_q;
	logic                   rsp_exc_q;
	logic [7:0]             rsp_exc_code_q;
	logic [`IOS_TRIP_W-1:0] trip_cause_q;
	logic [16:0]            end_addr;
	logic                   func_ok;
	logic                   qty_ok;
	logic                   addr_ok;

	ios_sync #(
		.W (FW)
	) u_sync_first (
		.clk     (clk),
		.sys_rst (sys_rst),
		.din     ({first_io_module_unavail, auxiliary_contact_module_out,
			first_io_module_out, first_io_module_in}),
		.dout    (first_s)
	);

	ios_sync #(
		.W (SW)
	) u_sync_second (
		.clk     (clk),
		.sys_rst (sys_rst),
		.din     ({second_io_module_unavail, second_io_module_out, second_io_module_in}),
		.dout    (second_s)
	);

	ios_sync #(
		.W (TW)
	) u_sync_trip (
		.clk     (clk),
		.sys_rst (sys_rst),
		.din     ({trip_unit_variant, reset_button, breaker_closed, confirm_key, trip_event}),
		.dout    (trip_s)
	);

	// Bit-valid strobes are quality data; held through their own synchroniser, of the same depth as the word's
	logic [`IOS_FIRST_W-1:0]  ok1_s;
	logic [`IOS_SECOND_W-1:0] ok2_s;

	ios_sync #(
		.W (`IOS_FIRST_W + `IOS_SECOND_W)
	) u_sync_ok (
		.clk     (clk),
		.sys_rst (sys_rst),
		.din     ({second_io_module_bit_ok, first_io_module_bit_ok}),
		.dout    ({ok2_s, ok1_s})
	);

	// Variant strap caught once the synchroniser has settled
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			strap_cnt_q <= '0;
			variant_q   <= IOS_VAR_BASIC;
		end else if (strap_cnt_q != `IOS_STRAP_CNT) begin
			strap_cnt_q <= strap_cnt_q + 1'b1;
			if (strap_cnt_q + 1'b1 == `IOS_STRAP_CNT) begin
				variant_q <= ios_variant_t'(trip_s[TW-1 -: 2]);
			end
		end
	end

	assign tif.trip_ev = trip_s[`IOS_TRIP_W-1:0];
	assign tif.key     = trip_s[`IOS_TRIP_W];
	assign tif.closed  = trip_s[`IOS_TRIP_W + 1];
	assign tif.button  = trip_s[`IOS_TRIP_W + 2];
	assign tif.variant = variant_q;

	ios_trip_latch #(
		.HOLD_MIN (HOLD_MIN),
		.HOLD_MAX (HOLD_MAX)
	) u_trip (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tif     (tif.latch)
	);

	// Register contents; unavailable words carry only the flag
	always_comb begin
		if (first_s[FW-1]) begin
			s1 = 16'h8000;
			q1 = 16'h8000;
		end else begin
			s1 = {1'b0, {`IOS_RSV1_W{1'b0}}, first_s[`IOS_FIRST_W-1:0]};
			q1 = {1'b1, {`IOS_RSV1_W{1'b0}}, ok1_s};
		end
		if (second_s[SW-1]) begin
			s2 = 16'h8000;
			q2 = 16'h8000;
		end else begin
			s2 = {1'b0, {`IOS_RSV2_W{1'b0}}, second_s[`IOS_SECOND_W-1:0]};
			q2 = {1'b1, {`IOS_RSV2_W{1'b0}}, ok2_s};
		end
	end

	always_comb begin
		case (ptr_q)
			`IOS_ADDR_Q1: rd_word = q1;
			`IOS_ADDR_S1: rd_word = s1;
			`IOS_ADDR_Q2: rd_word = q2;
			`IOS_ADDR_S2: rd_word = s2;
			default:      rd_word = 16'h0000;
		endcase
	end

	assign end_addr = {1'b0, req_addr} + {9'h000, req_qty} - 17'h00001;
	assign func_ok  = req_func == `IOS_FN_RD_HOLD || req_func == `IOS_FN_RD_INPUT;
	assign qty_ok   = req_qty != 8'h00 && req_qty <= `IOS_MAX_QTY;
	assign addr_ok  = req_addr >= `IOS_ADDR_Q1 && end_addr <= {1'b0, `IOS_ADDR_S2};

	// Request sequencing: one answer stream per accepted request
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q           <= IOS_RSP_IDLE;
			ptr_q          <= '0;
			left_q         <= '0;
			req_ready_q    <= 1'b0;
			rsp_exc_code_q <= '0;
		end else begin
			case (st_q)
				IOS_RSP_IDLE: begin
					req_ready_q <= 1'b1;
					if (req_valid && req_ready_q) begin
						req_ready_q <= 1'b0;
						ptr_q       <= req_addr;
						left_q      <= req_qty;
						if (!func_ok) begin
							st_q           <= IOS_RSP_EXC;
							rsp_exc_code_q <= `IOS_EXC_FUNC;
						end else if (!qty_ok) begin
							st_q           <= IOS_RSP_EXC;
							rsp_exc_code_q <= `IOS_EXC_VALUE;
						end else if (!addr_ok) begin
							st_q           <= IOS_RSP_EXC;
							rsp_exc_code_q <= `IOS_EXC_ADDR;
						end else begin
							st_q           <= IOS_RSP_STREAM;
							rsp_exc_code_q <= 8'h00;
						end
					end
				end
				IOS_RSP_STREAM: begin
					ptr_q  <= ptr_q + 16'h0001;
					left_q <= left_q - 8'h01;
					if (left_q == 8'h01) begin
						st_q        <= IOS_RSP_IDLE;
						req_ready_q <= 1'b1;
					end
				end
				IOS_RSP_EXC: begin
					st_q        <= IOS_RSP_IDLE;
					req_ready_q <= 1'b1;
				end
				default: begin
					st_q <= IOS_RSP_IDLE;
				end
			endcase
		end
	end

	// Answer outputs
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rsp_valid_q <= 1'b0;
			rsp_data_q  <= '0;
			rsp_last_q  <= 1'b0;
			rsp_exc_q   <= 1'b0;
		end else begin
			rsp_valid_q <= st_q == IOS_RSP_STREAM || st_q == IOS_RSP_EXC;
			rsp_data_q  <= st_q == IOS_RSP_STREAM ? rd_word : 16'h0000;
			rsp_last_q  <= (st_q == IOS_RSP_STREAM && left_q == 8'h01) || st_q == IOS_RSP_EXC;
			rsp_exc_q   <= st_q == IOS_RSP_EXC;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			trip_cause_q <= '0;
		end else begin
			trip_cause_q <= tif.cause;
		end
	end

	assign req_ready    = req_ready_q;
	assign rsp_valid    = rsp_valid_q;
	assign rsp_data     = rsp_data_q;
	assign rsp_last     = rsp_last_q;
	assign rsp_exc      = rsp_exc_q;
	assign rsp_exc_code = rsp_exc_code_q;
	assign trip_cause   = trip_cause_q;

endmodule

// [tb/ios_status_regs_checker.sv]
`timescale 1ns/1ps
module ios_status_regs_checker (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic [14:0] trip_event,
	input wire logic        confirm_key,
	input wire logic        breaker_closed,
	input wire logic        reset_button,
	input wire logic [1:0]  trip_unit_variant,
	input wire logic        req_valid,
	input wire logic [7:0]  req_func,
	input wire logic [15:0] req_addr,
	input wire logic [7:0]  req_qty,
	input wire logic        req_ready,
	input wire logic        rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire logic        rsp_last,
	input wire logic        rsp_exc,
	input wire logic [7:0]  rsp_exc_code,
	input wire logic [14:0] trip_cause
);
	logic [15:0] addr_q;
	logic [3:0]  quiet_q;
	logic        take;
	logic        rd;
	assign take = req_valid && req_ready;
	assign rd = rsp_valid && !rsp_exc;
	// Address of the word now on the answer port
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			addr_q <= 16'h0;
		end else if (take) begin
			addr_q <= req_addr;
		end else if (rsp_valid) begin
			addr_q <= addr_q + 16'h1;
		end
	end
	// Cycles since any clearing input was high
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			quiet_q <= 4'h0;
		end else if (confirm_key || breaker_closed || reset_button) begin
			quiet_q <= 4'h0;
		end else if (quiet_q != 4'hf) begin
			quiet_q <= quiet_q + 4'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_bad_addr;
		take && req_func == 8'h03 && req_qty == 8'h01 && (req_addr < 16'h7d01 ||
			req_addr > 16'h7d04) |-> ##2 rsp_valid && rsp_exc && rsp_exc_code == 8'h02;
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("bad address kept");
	property p_write;
		take && req_func == 8'h06 |-> ##2 rsp_valid && rsp_exc && rsp_last &&
			rsp_exc_code == 8'h01 && rsp_data == 16'h0;
	endproperty
	a_write: assert property (p_write) else $error("write not refused");
	property p_qual;
		rd && addr_q == 16'h7d01 |-> rsp_data[15] && rsp_data[14:11] == 4'h0;
	endproperty
	a_qual: assert property (p_qual) else $error("quality word bad");
	property p_rsv1;
		rd && addr_q == 16'h7d02 |-> rsp_data[14:11] == 4'h0;
	endproperty
	a_rsv1: assert property (p_rsv1) else $error("first reserved set");
	property p_rsv2;
		rd && addr_q == 16'h7d04 |-> rsp_data[14:9] == 6'h0;
	endproperty
	a_rsv2: assert property (p_rsv2) else $error("second reserved set");
	property p_unav;
		rd && (addr_q == 16'h7d02 || addr_q == 16'h7d04) && rsp_data[15]
			|-> rsp_data[14:0] == 15'h0;
	endproperty
	a_unav: assert property (p_unav) else $error("unavailable word bad");
	property p_trip_set;
		trip_event[0] |-> ##[1:8] trip_cause[0];
	endproperty
	a_trip_set: assert property (p_trip_set) else $error("cause not set");
	property p_trip_hold;
		quiet_q == 4'hf |-> (trip_cause & $past(trip_cause)) == $past(trip_cause);
	endproperty
	a_trip_hold: assert property (p_trip_hold) else $error("cause dropped");
	property p_ext_clr;
		trip_unit_variant == 2'b01 && $rose(breaker_closed) && trip_event == 15'h0
			|-> ##[2:8] trip_cause == 15'h0;
	endproperty
	a_ext_clr: assert property (p_ext_clr) else $error("close did not clear");
	c_exc: cover property (rsp_valid && rsp_exc);
	c_multi: cover property (rsp_valid && rsp_last && !rsp_exc);
	c_clear: cover property ((trip_cause != 15'h0) ##1 (trip_cause == 15'h0));
endmodule
bind ios_status_regs ios_status_regs_checker u_chk (.*);

// [tb/ios_master.sv]
`timescale 1ns/1ps
module ios_master (
	input  wire logic        clk,
	input  wire logic        req_ready,
	output logic             req_valid,
	output logic [7:0]       req_func,
	output logic [15:0]      req_addr,
	output logic [7:0]       req_qty,
	output logic             hung
);
	int gap = 0;
	initial begin
		req_valid = 1'b0;
		req_func = 8'h0;
		req_addr = 16'h0;
		req_qty = 8'h0;
		hung = 1'b0;
	end
	// One request, held until taken, then scrambled
	task automatic rd(input logic [7:0] f, input logic [15:0] num, input logic [7:0] q);
		int n;
		repeat (gap) @(negedge clk);
		@(negedge clk);
		req_valid = 1'b1;
		req_func = f;
		req_addr = num - 16'h1;
		req_qty = q;
		for (n = 0; req_ready !== 1'b1; n++) begin
			if (n == 100) begin
				hung = 1'b1;
			end
			@(negedge clk);
		end
		@(negedge clk);
		req_valid = 1'b0;
		req_func = ~req_func;
		req_addr = ~req_addr;
		req_qty = ~req_qty;
	endtask
endmodule

// [tb/ios_status_regs_test.sv]
`timescale 1ns/1ps
module ios_status_regs_test;
	typedef struct packed {
		logic [15:0] data;
		logic        last;
		logic        exc;
		logic [7:0]  code;
	} ios_note_t;
	logic        clk, sys_rst, hung;
	logic [5:0]  first_io_module_in, second_io_module_in;
	logic [2:0]  first_io_module_out, second_io_module_out;
	logic [1:0]  auxiliary_contact_module_out, trip_unit_variant;
	logic [10:0] first_io_module_bit_ok;
	logic [8:0]  second_io_module_bit_ok;
	logic        first_io_module_unavail, second_io_module_unavail;
	logic [14:0] trip_event, trip_cause;
	logic        confirm_key, breaker_closed, reset_button;
	logic        req_valid, req_ready, rsp_valid, rsp_last, rsp_exc;
	logic [7:0]  req_func, req_qty, rsp_exc_code;
	logic [15:0] req_addr, rsp_data;
	int          err_count, samples_checked;
	int          hold_len[3] = '{3, 30, 12};
	ios_note_t   notes[$];
	ios_note_t   got;
	ios_status_regs #(.HOLD_MIN(32'h5), .HOLD_MAX(32'h14)) u_dut (.*);
	ios_master u_mst (.*);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic wrap_up();
		$display("Checked %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chk_note(input ios_note_t e, input ios_note_t g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] answer expected %h seen %h", e, g);
		end
	endtask
	function automatic logic [15:0] word(input logic [15:0] a);
		case (a)
			16'h7d01: return first_io_module_unavail ? 16'h8000 :
				{5'h10, first_io_module_bit_ok};
			16'h7d02: return first_io_module_unavail ? 16'h8000 : {5'h0,
				auxiliary_contact_module_out, first_io_module_out, first_io_module_in};
			16'h7d03: return second_io_module_unavail ? 16'h8000 :
				{7'h40, second_io_module_bit_ok};
			default: return second_io_module_unavail ? 16'h8000 :
				{7'h0, second_io_module_out, second_io_module_in};
		endcase
	endfunction
	task automatic read(input logic [7:0] f, input logic [15:0] num, input logic [7:0] q);
		for (int i = 0; i < q; i++) begin
			notes.push_back({word(num - 16'h1 + 16'(i)), i == q - 1, 9'h0});
		end
		u_mst.rd(f, num, q);
	endtask
	task automatic refuse(input logic [7:0] f, input logic [15:0] num, input logic [7:0] q,
			input logic [7:0] code);
		notes.push_back({16'h0, 2'b11, code});
		u_mst.rd(f, num, q);
	endtask
	task automatic drain();
		for (int n = 0; notes.size() > 0; n++) begin
			if (n == 50) begin
				err_count++;
				wrap_up();
			end
			@(negedge clk);
		end
	endtask
	task automatic restart(input logic [1:0] v);
		@(negedge clk);
		sys_rst = 1'b1;
		trip_unit_variant = v;
		repeat (8) @(negedge clk);
		chk("ready in reset", 16'h0, {15'h0, req_ready});
		sys_rst = 1'b0;
		repeat (12) @(negedge clk);
	endtask
	task automatic trip(input logic [14:0] t);
		trip_event = t;
		repeat (3) @(negedge clk);
		trip_event = 15'h0;
		repeat (10) @(negedge clk);
	endtask
	task automatic key_press();
		confirm_key = 1'b1;
		repeat (3) @(negedge clk);
		confirm_key = 1'b0;
		repeat (8) @(negedge clk);
	endtask
	always @(negedge clk) begin
		if (rsp_valid === 1'b1) begin
			got = {rsp_data, rsp_last, rsp_exc, rsp_exc_code & {8{rsp_exc}}};
			if (notes.size() == 0) begin
				err_count++;
				$display("[FAIL] answer expected none seen %h", got);
			end else begin
				chk_note(notes.pop_front(), got);
			end
		end
	end
	always @(posedge hung) begin
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (20000) @(negedge clk);
		err_count++;
		wrap_up();
	end
	initial begin
		{sys_rst, confirm_key, breaker_closed, reset_button} = 4'h8;
		{first_io_module_in, first_io_module_out, auxiliary_contact_module_out} = 11'h0;
		{second_io_module_in, second_io_module_out, trip_unit_variant} = 11'h0;
		{first_io_module_bit_ok, second_io_module_bit_ok} = 20'h0;
		{first_io_module_unavail, second_io_module_unavail, trip_event} = 17'h0;
		void'($urandom(34));
		restart(2'b00);
		for (int k = 0; k < 6; k++) begin
			{first_io_module_in, first_io_module_out, auxiliary_contact_module_out} = 11'($urandom);
			{second_io_module_in, second_io_module_out} = 9'($urandom);
			first_io_module_bit_ok = 11'($urandom);
			second_io_module_bit_ok = 9'($urandom);
			{first_io_module_unavail, second_io_module_unavail} = k > 3 ? 2'(k - 2) : 2'h0;
			u_mst.gap = $urandom % 3;
			repeat (8) @(negedge clk);
			read(8'h03, 16'd32002, 8'h4);
			read(8'h04, 16'd32005, 8'h1);
			drain();
		end
		$display("Test readout finished");
		refuse(8'h06, 16'd32003, 8'h1, 8'h01);
		refuse(8'h10, 16'd32010, 8'h0, 8'h01);
		refuse(8'h03, 16'd32002, 8'h0, 8'h03);
		refuse(8'h03, 16'd32001, 8'h1, 8'h02);
		refuse(8'h04, 16'd32005, 8'h2, 8'h02);
		read(8'h03, 16'd32003, 8'h1);
		drain();
		$display("Test refusals finished");
		trip(15'h0005);
		chk("cause latched", 16'h5, {1'b0, trip_cause});
		key_press();
		chk("one press", 16'h5, {1'b0, trip_cause});
		key_press();
		chk("two presses", 16'h0, {1'b0, trip_cause});
		$display("Test basic clear finished");
		restart(2'b01);
		trip(15'h4001);
		key_press();
		key_press();
		chk("keys ignored", 16'h4001, {1'b0, trip_cause});
		breaker_closed = 1'b1;
		repeat (10) @(negedge clk);
		chk("closed again", 16'h0, {1'b0, trip_cause});
		breaker_closed = 1'b0;
		$display("Test close clear finished");
		restart(2'b10);
		trip(15'h7fff);
		for (int i = 0; i < 3; i++) begin
			reset_button = 1'b1;
			repeat (hold_len[i]) @(negedge clk);
			reset_button = 1'b0;
			repeat (10) @(negedge clk);
			chk("button hold", i == 2 ? 16'h0 : 16'h7fff, {1'b0, trip_cause});
		end
		$display("Test button clear finished");
		restart(2'b11);
		trip(15'h0002);
		key_press();
		key_press();
		breaker_closed = 1'b1;
		repeat (10) @(negedge clk);
		breaker_closed = 1'b0;
		chk("no variant", 16'h2, {1'b0, trip_cause});
		$display("Test no variant finished");
		wrap_up();
	end
endmodule
